// ---- hdl/mcuad_pkg.sv ----
// Shared constants and carrier types for the microcontroller address and interrupt glue
// ==========================================================================================
// Function
// RULE1: Decode 0000h-5FFFh as RAM, valid to 03C7h
// RULE2: 6000h-7FFFh peripheral space, 32 regions of 256
// RULE3: Select pin, power-clock-reset, contactless regions; rest reserved
// RULE4: Paged address is page register over R0/R1
// RULE5: Pointer access applies full 16-bit pointer
// RULE6: Program fetch 0000h-AFFFh maps onto ROM
// RULE7: Power bit 7 doubles debug serial baud
// RULE8: Writing power bit 1 enters power-down
// RULE9: Software keeps bit 0 zero; 6-2 read-only
// RULE10: Interrupt n vectors to 0003h plus 8n
// RULE11: Same level ties resolved by lowest number
// RULE12: Enabled interrupt request wakes from power-down
// RULE13: Two enable and two priority registers
// RULE14: Enable bit 7 clear masks all sources
// RULE15: High priority preempts low; wins simultaneous arrival
// RULE16: Invalid or reserved accesses change nothing, read zero
package mcuad_pkg;

  // ========================================================================================
  // Special function register offsets
  localparam logic [7:0]  SFR_POWER_CONTROL   = 8'h87;
  localparam logic [7:0]  SFR_IRQ_ENABLE_A    = 8'hA8;
  localparam logic [7:0]  SFR_IRQ_PRIORITY_A  = 8'hB8;
  localparam logic [7:0]  SFR_IRQ_ENABLE_B    = 8'hE8;
  localparam logic [7:0]  SFR_IRQ_PRIORITY_B  = 8'hF8;
  localparam logic [7:0]  SFR_EXT_RAM_PAGE    = 8'hFA;

  // ========================================================================================
  // Field positions and reset values
  localparam int          PWR_BAUD_DOUBLE_BIT = 7;
  localparam int          PWR_POWER_DOWN_BIT  = 1;
  localparam int          PWR_RESERVED0_BIT   = 0;
  localparam logic [7:0]  PWR_WRITABLE_MASK   = 8'h83;
  localparam int          IEA_GLOBAL_BIT      = 7;
  localparam logic [7:0]  SFR_RESET_VALUE     = 8'h00;

  // ========================================================================================
  // External data map
  localparam logic [15:0] XRAM_VALID_LAST     = 16'h03C7;
  localparam logic [15:0] XRAM_SPACE_LAST     = 16'h5FFF;
  localparam logic [15:0] PERIPH_SPACE_FIRST  = 16'h6000;
  localparam logic [15:0] PERIPH_SPACE_LAST   = 16'h7FFF;
  localparam logic [7:0]  PERIPH_PIN_REGION   = 8'h61;
  localparam logic [7:0]  PERIPH_PCR_REGION   = 8'h62;
  localparam logic [7:0]  PERIPH_CTL_REGION   = 8'h63;
  localparam logic [7:0]  PERIPH_CTL_LAST_LO  = 8'h3F;
  localparam logic [15:0] ROM_LAST            = 16'hAFFF;

  // ========================================================================================
  // Interrupt map
  localparam int          IRQ_COUNT           = 15;
  localparam logic [15:0] IRQ_VECTOR_BASE     = 16'h0003;
  localparam int          IRQ_VECTOR_SHIFT    = 3;
  localparam int          IRQ_PIN_A_NUM       = 0;
  localparam int          IRQ_PIN_B_NUM       = 2;
  // Sources 0..6 use enable/priority A bits 0..6, 9..14 use B bits 2..7, 7 and 8 are unused
  localparam int          IRQ_B_FIRST_NUM     = 9;
  localparam int          IRQ_B_BIT_OFFSET    = 7;
  localparam logic [14:0] IRQ_IMPLEMENTED     = 15'h7E7F;

  // ========================================================================================
  // Carrier types
  typedef struct packed {
    logic        req;
    logic        write;
    logic        paged;
    logic [15:0] dataPtr;
    logic [7:0]  idxReg;
    logic [7:0]  wrData;
  } mcuad_xreq_t;

  typedef struct packed {
    logic ram;
    logic pinCfg;
    logic power_clock_reset_ctl;
    logic ctless;
  } mcuad_xsel_t;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } mcuad_sfr_t;

endpackage

// ---- hdl/mcuad_irq_arb.sv ----
// Interrupt arbiter: picks the winning pending source by level and number
`timescale 1ns/1ps
module mcuad_irq_arb (
  input  wire logic [14:0] pending,
  input  wire logic [14:0] prioHigh,
  input  wire logic        svcHigh,
  input  wire logic        svcLow,
  output logic             winValid,
  output logic             winHigh,
  output logic [3:0]       winNum
);

  logic [14:0] hiReq;
  logic [14:0] loReq;

  // ========================================================================================
  // Per-source split into the two levels
  genvar g;
  generate
    for (g = 0; g < mcuad_pkg::IRQ_COUNT; g++) begin : gLevel
      assign hiReq[g] = pending[g] & prioHigh[g];
      assign loReq[g] = pending[g] & ~prioHigh[g];
    end
  endgenerate

  function automatic logic [3:0] lowestSet(input logic [14:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = mcuad_pkg::IRQ_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // ========================================================================================
  // High level beats low; inside a level the lowest number wins
  always_comb begin
    winValid = 1'b0;
    winHigh  = 1'b0;
    winNum   = 4'h0;
    if (|hiReq && !svcHigh) begin // RULE15
      winValid = 1'b1;
      winHigh  = 1'b1;
      winNum   = lowestSet(hiReq); // RULE11
    end else if (|loReq && !svcHigh && !svcLow) begin
      winValid = 1'b1;
      winNum   = lowestSet(loReq); // RULE11
    end
  end

endmodule // mcuad_irq_arb

// ---- hdl/mcuad_glue.sv ----
// Address decode, power control and interrupt vectoring around the embedded CPU core
`timescale 1ns/1ps
module mcuad_glue (
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  // Special function register port from the CPU
  input  wire mcuad_pkg::mcuad_sfr_t  sfrReq,
  output logic [7:0]                  sfrRdData,
  // External data access from the CPU
  input  wire mcuad_pkg::mcuad_xreq_t xReq,
  output logic [15:0]                 xAddr,
  output mcuad_pkg::mcuad_xsel_t      xSel,
  output logic                        xWrEn,
  output logic [7:0]                  xWrData,
  input  wire logic [7:0]             ramRdData,
  input  wire logic [7:0]             pinRdData,
  input  wire logic [7:0]             pcrRdData,
  input  wire logic [7:0]             ctlRdData,
  output logic [7:0]                  xRdData,
  // Program fetch
  input  wire logic                   fetchReq,
  input  wire logic [15:0]            fetchAddr,
  output logic                        romEn,
  output logic [15:0]                 romAddr,
  input  wire logic [7:0]             romData,
  output logic [7:0]                  fetchData,
  // Power control outputs
  output logic                        serialBaudDouble,
  output logic                        cpuPowerDown,
  // Interrupt sources and CPU handshake
  input  wire logic                   extIrqPinA,
  input  wire logic                   extIrqPinB,
  input  wire logic [14:0]            irqSrc,
  output logic                        irqReq,
  output logic [3:0]                  irqNum,
  output logic [15:0]                 irqVector,
  input  wire logic                   irqAck,
  input  wire logic                   irqReti
);

  // ========================================================================================
  // Register state
  logic [7:0]  powerCtl_ff,  nxt_powerCtl;
  logic [7:0]  enableA_ff,   nxt_enableA;
  logic [7:0]  enableB_ff,   nxt_enableB;
  logic [7:0]  prioA_ff,     nxt_prioA;
  logic [7:0]  prioB_ff,     nxt_prioB;
  logic [7:0]  ramPage_ff,   nxt_ramPage;
  logic [7:0]  sfrRd_ff,     nxt_sfrRd;
  logic [7:0]  xRd_ff,       nxt_xRd;
  logic [7:0]  fetch_ff,     nxt_fetch;
  logic        svcHigh_ff,   nxt_svcHigh;
  logic        svcLow_ff,    nxt_svcLow;
  logic        irqReq_ff,    nxt_irqReq;
  logic        irqHigh_ff;
  logic [3:0]  irqNum_ff;
  logic [15:0] irqVec_ff,    nxt_irqVec;
  logic [2:0]  pinASync_ff;
  logic [2:0]  pinBSync_ff;
  logic        pinA_ff,      nxt_pinA;
  logic        pinB_ff,      nxt_pinB;

  logic        sfrWr;
  logic [14:0] srcAll;
  logic [14:0] enAll;
  logic [14:0] prioAll;
  logic [14:0] pending;
  logic        anyPending;
  logic        winValid;
  logic        winHigh;
  logic [3:0]  winNum;
  logic        ramHit;
  logic        periph;

  // ========================================================================================
  // External data address forming and decode
  always_comb begin
    xAddr = xReq.paged ? {ramPage_ff, xReq.idxReg} : xReq.dataPtr; // RULE4 RULE5
    ramHit = xAddr <= mcuad_pkg::XRAM_VALID_LAST; // RULE1
    periph = (xAddr >= mcuad_pkg::PERIPH_SPACE_FIRST) &&
             (xAddr <= mcuad_pkg::PERIPH_SPACE_LAST); // RULE2
    xSel.ram    = xReq.req && ramHit;
    xSel.pinCfg = xReq.req && periph && (xAddr[15:8] == mcuad_pkg::PERIPH_PIN_REGION); // RULE3
    xSel.power_clock_reset_ctl    = xReq.req && periph && (xAddr[15:8] == mcuad_pkg::PERIPH_PCR_REGION); // RULE3
    xSel.ctless = xReq.req && periph && (xAddr[15:8] == mcuad_pkg::PERIPH_CTL_REGION) &&
                  (xAddr[7:0] <= mcuad_pkg::PERIPH_CTL_LAST_LO); // RULE3
    // Strobes only reach a selected target, so holes see no write
    xWrEn   = xReq.write && (|xSel); // RULE16
    xWrData = xReq.wrData;
  end

  // Read data is captured one cycle after the request; holes give zero
  always_comb begin
    nxt_xRd = 8'h00; // RULE16
    if (xReq.req && !xReq.write) begin
      if (xSel.ram) begin
        nxt_xRd = ramRdData;
      end else if (xSel.pinCfg) begin
        nxt_xRd = pinRdData;
      end else if (xSel.power_clock_reset_ctl) begin
        nxt_xRd = pcrRdData;
      end else if (xSel.ctless) begin
        nxt_xRd = ctlRdData;
      end
    end else begin
      nxt_xRd = xRd_ff;
    end
  end

  // ========================================================================================
  // Program fetch window
  always_comb begin
    romEn     = fetchReq && (fetchAddr <= mcuad_pkg::ROM_LAST); // RULE6
    romAddr   = fetchAddr;
    nxt_fetch = fetch_ff;
    if (fetchReq) begin
      nxt_fetch = romEn ? romData : 8'h00;
    end
  end

  // ========================================================================================
  // Pin interrupt synchronisers: a level counts once stages two and three agree
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinASync_ff <= 3'h0;
      pinBSync_ff <= 3'h0;
    end else begin
      pinASync_ff <= {pinASync_ff[1:0], extIrqPinA};
      pinBSync_ff <= {pinBSync_ff[1:0], extIrqPinB};
    end
  end

  always_comb begin
    nxt_pinA = (pinASync_ff[1] == pinASync_ff[2]) ? pinASync_ff[2] : pinA_ff;
    nxt_pinB = (pinBSync_ff[1] == pinBSync_ff[2]) ? pinBSync_ff[2] : pinB_ff;
  end

  // ========================================================================================
  // Interrupt enable and level mapping
  always_comb begin
    srcAll = irqSrc;
    srcAll[mcuad_pkg::IRQ_PIN_A_NUM] = pinA_ff;
    srcAll[mcuad_pkg::IRQ_PIN_B_NUM] = pinB_ff;
    enAll   = 15'h0000;
    prioAll = 15'h0000;
    for (int i = 0; i < mcuad_pkg::IRQ_COUNT; i++) begin
      if (i < mcuad_pkg::IRQ_B_FIRST_NUM) begin
        enAll[i]   = (i < mcuad_pkg::IEA_GLOBAL_BIT) ? enableA_ff[i] : 1'b0; // RULE13
        prioAll[i] = (i < mcuad_pkg::IEA_GLOBAL_BIT) ? prioA_ff[i] : 1'b0; // RULE13
      end else begin
        enAll[i]   = enableB_ff[i - mcuad_pkg::IRQ_B_BIT_OFFSET]; // RULE13
        prioAll[i] = prioB_ff[i - mcuad_pkg::IRQ_B_BIT_OFFSET]; // RULE13
      end
    end
    pending = srcAll & enAll & mcuad_pkg::IRQ_IMPLEMENTED &
              {15{enableA_ff[mcuad_pkg::IEA_GLOBAL_BIT]}}; // RULE14
    anyPending = |pending;
  end

  mcuad_irq_arb uArb (
    .pending  (pending),
    .prioHigh (prioAll),
    .svcHigh  (svcHigh_ff),
    .svcLow   (svcLow_ff),
    .winValid (winValid),
    .winHigh  (winHigh),
    .winNum   (winNum)
  );

  // ========================================================================================
  // Request, vector and in-service levels
  always_comb begin
    nxt_irqReq  = winValid && !irqAck;
    nxt_irqVec  = mcuad_pkg::IRQ_VECTOR_BASE +
                  {9'h000, winNum, 3'h0}; // RULE10
    nxt_svcHigh = svcHigh_ff;
    nxt_svcLow  = svcLow_ff;
    // A return closes the most recent level: high when it is open
    if (irqReti) begin
      if (svcHigh_ff) begin
        nxt_svcHigh = 1'b0;
      end else begin
        nxt_svcLow = 1'b0;
      end
    end
    if (irqAck && irqReq_ff) begin
      if (irqHigh_ff) begin
        nxt_svcHigh = 1'b1; // RULE15
      end else begin
        nxt_svcLow = 1'b1;
      end
    end
  end

  // ========================================================================================
  // Register file writes and reads
  always_comb begin
    sfrWr        = sfrReq.wrEn;
    nxt_powerCtl = powerCtl_ff;
    nxt_enableA  = enableA_ff;
    nxt_enableB  = enableB_ff;
    nxt_prioA    = prioA_ff;
    nxt_prioB    = prioB_ff;
    nxt_ramPage  = ramPage_ff;
    if (sfrWr) begin
      case (sfrReq.addr)
        mcuad_pkg::SFR_POWER_CONTROL: begin
          nxt_powerCtl = sfrReq.wrData & mcuad_pkg::PWR_WRITABLE_MASK; // RULE7 RULE8 RULE9
        end
        mcuad_pkg::SFR_IRQ_ENABLE_A:   nxt_enableA = sfrReq.wrData;
        mcuad_pkg::SFR_IRQ_ENABLE_B:   nxt_enableB = sfrReq.wrData;
        mcuad_pkg::SFR_IRQ_PRIORITY_A: nxt_prioA   = sfrReq.wrData;
        mcuad_pkg::SFR_IRQ_PRIORITY_B: nxt_prioB   = sfrReq.wrData;
        mcuad_pkg::SFR_EXT_RAM_PAGE:   nxt_ramPage = sfrReq.wrData;
        default: begin
        end
      endcase
    end
    // Wake beats a same-cycle sleep write, so a pending source is never slept through
    if (anyPending) begin
      nxt_powerCtl[mcuad_pkg::PWR_POWER_DOWN_BIT] = 1'b0; // RULE12
    end
    nxt_sfrRd = sfrRd_ff;
    if (sfrReq.rdEn) begin
      case (sfrReq.addr)
        mcuad_pkg::SFR_POWER_CONTROL:  nxt_sfrRd = powerCtl_ff;
        mcuad_pkg::SFR_IRQ_ENABLE_A:   nxt_sfrRd = enableA_ff;
        mcuad_pkg::SFR_IRQ_ENABLE_B:   nxt_sfrRd = enableB_ff;
        mcuad_pkg::SFR_IRQ_PRIORITY_A: nxt_sfrRd = prioA_ff;
        mcuad_pkg::SFR_IRQ_PRIORITY_B: nxt_sfrRd = prioB_ff;
        mcuad_pkg::SFR_EXT_RAM_PAGE:   nxt_sfrRd = ramPage_ff;
        default:                       nxt_sfrRd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      powerCtl_ff <= mcuad_pkg::SFR_RESET_VALUE;
      enableA_ff  <= mcuad_pkg::SFR_RESET_VALUE;
      enableB_ff  <= mcuad_pkg::SFR_RESET_VALUE;
      prioA_ff    <= mcuad_pkg::SFR_RESET_VALUE;
      prioB_ff    <= mcuad_pkg::SFR_RESET_VALUE;
      ramPage_ff  <= mcuad_pkg::SFR_RESET_VALUE;
      sfrRd_ff    <= 8'h00;
      xRd_ff      <= 8'h00;
      fetch_ff    <= 8'h00;
      svcHigh_ff  <= 1'b0;
      svcLow_ff   <= 1'b0;
      irqReq_ff   <= 1'b0;
      irqHigh_ff  <= 1'b0;
      irqNum_ff   <= 4'h0;
      irqVec_ff   <= 16'h0000;
      pinA_ff     <= 1'b0;
      pinB_ff     <= 1'b0;
    end else begin
      powerCtl_ff <= nxt_powerCtl;
      enableA_ff  <= nxt_enableA;
      enableB_ff  <= nxt_enableB;
      prioA_ff    <= nxt_prioA;
      prioB_ff    <= nxt_prioB;
      ramPage_ff  <= nxt_ramPage;
      sfrRd_ff    <= nxt_sfrRd;
      xRd_ff      <= nxt_xRd;
      fetch_ff    <= nxt_fetch;
      svcHigh_ff  <= nxt_svcHigh;
      svcLow_ff   <= nxt_svcLow;
      irqReq_ff   <= nxt_irqReq;
      irqHigh_ff  <= winHigh;
      irqNum_ff   <= winNum;
      irqVec_ff   <= nxt_irqVec;
      pinA_ff     <= nxt_pinA;
      pinB_ff     <= nxt_pinB;
    end
  end

  // ========================================================================================
  // Outputs
  assign sfrRdData        = sfrRd_ff;
  assign xRdData          = xRd_ff;
  assign fetchData        = fetch_ff;
  assign serialBaudDouble = powerCtl_ff[mcuad_pkg::PWR_BAUD_DOUBLE_BIT]; // RULE7
  assign cpuPowerDown     = powerCtl_ff[mcuad_pkg::PWR_POWER_DOWN_BIT]; // RULE8
  assign irqReq           = irqReq_ff;
  assign irqNum           = irqNum_ff;
  assign irqVector        = irqVec_ff;

endmodule // mcuad_glue

// ---- verif/mcuad_glue_properties.sv ----
// Assertion checker for the address decode, power control and interrupt glue
`timescale 1ns/1ps
module mcuad_glue_properties (
  input wire logic                   core_clk,
  input wire logic                   rstn,
  input wire mcuad_pkg::mcuad_sfr_t  sfrReq,
  input wire logic [7:0]             sfrRdData,
  input wire mcuad_pkg::mcuad_xreq_t xReq,
  input wire logic [15:0]            xAddr,
  input wire mcuad_pkg::mcuad_xsel_t xSel,
  input wire logic                   xWrEn,
  input wire logic                   fetchReq,
  input wire logic [15:0]            fetchAddr,
  input wire logic                   romEn,
  input wire logic                   serialBaudDouble,
  input wire logic                   cpuPowerDown,
  input wire logic                   irqReq,
  input wire logic [3:0]             irqNum,
  input wire logic [15:0]            irqVector
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Helpers
  logic pcw;
  logic pdw;
  logic rsv;
  assign pcw = sfrReq.wrEn && sfrReq.addr == 8'h87;
  assign pdw = pcw && sfrReq.wrData[1];
  assign rsv = xAddr inside {[16'h03C8:16'h60FF], [16'h6340:16'hFFFF]};
  // ==========================================================================
  // Properties
  property p_vec;
    irqReq |-> irqVector == 16'h0003 + {9'h000, irqNum, 3'h0};
  endproperty
  property p_ram;
    xReq.req && !xReq.paged && xReq.dataPtr <= 16'h03C7 |-> xSel == 4'h8 && xAddr == xReq.dataPtr;
  endproperty
  property p_rsv;
    xReq.req && rsv |-> xSel == 4'h0 && !xWrEn;
  endproperty
  property p_per;
    xReq.req && xAddr[15:8] inside {8'h61, 8'h62} |-> xSel == (xAddr[8] ? 4'h4 : 4'h2);
  endproperty
  property p_pag;
    xReq.req && xReq.paged |-> xAddr[7:0] == xReq.idxReg;
  endproperty
  property p_rom;
    fetchReq |-> romEn == (fetchAddr <= 16'hAFFF);
  endproperty
  property p_baud;
    pcw |=> serialBaudDouble == $past(sfrReq.wrData[7]);
  endproperty
  property p_pd;
    $rose(cpuPowerDown) |-> $past(pdw);
  endproperty
  property p_ro;
    sfrReq.rdEn && sfrReq.addr == 8'h87 |=> sfrRdData[6:2] == 5'h00;
  endproperty
  property p_wake;
    $rose(irqReq) |-> !cpuPowerDown;
  endproperty
  a_vec: assert property (p_vec) else $error("vector does not match number");
  a_ram: assert property (p_ram) else $error("valid RAM not selected");
  a_rsv: assert property (p_rsv) else $error("reserved address selected");
  a_per: assert property (p_per) else $error("peripheral region select wrong");
  a_pag: assert property (p_pag) else $error("paged low byte wrong");
  a_rom: assert property (p_rom) else $error("ROM enable wrong");
  a_baud: assert property (p_baud) else $error("baud double not updated");
  a_pd: assert property (p_pd) else $error("power-down without write");
  a_ro: assert property (p_ro) else $error("read-only bits not zero");
  a_wake: assert property (p_wake) else $error("request did not wake");
  c_low: cover property (irqReq && irqNum == 4'hE);
  c_wake: cover property ($fell(cpuPowerDown));
  c_ctl: cover property (xReq.req && xSel.ctless);
endmodule // mcuad_glue_properties

bind mcuad_glue mcuad_glue_properties i_props (.core_clk, .rstn, .sfrReq, .sfrRdData, .xReq,
  .xAddr, .xSel, .xWrEn, .fetchReq, .fetchAddr, .romEn, .serialBaudDouble, .cpuPowerDown,
  .irqReq, .irqNum, .irqVector);

// ---- verif/mcuad_cpu_model.sv ----
// Behavioural model of the CPU side of the interrupt handshake
`timescale 1ns/1ps
module mcuad_cpu_model (
  input  wire logic       core_clk,
  input  wire logic       irqReq,
  input  wire logic [3:0] irqNum,
  input  wire logic [1:0] ackDly,
  output logic            irqAck,
  output logic [3:0]      takenNum
);
  int waitCnt = 0;
  initial begin
    irqAck = 1'b0;
    takenNum = 4'h0;
  end
  // Request must stand two cycles at least, so one still falling after an ack is not taken twice
  always @(negedge core_clk) begin
    irqAck <= 1'b0;
    waitCnt <= irqReq ? waitCnt + 1 : 0;
    if (irqReq && !irqAck && waitCnt >= 2 + ackDly) begin
      irqAck <= 1'b1;
      takenNum <= irqNum;
      waitCnt <= 0;
    end
  end
endmodule // mcuad_cpu_model

// ---- verif/tb.sv ----
// Self-checking testbench for the address decode, power control and interrupt glue
`timescale 1ns/1ps
module tb;
  logic core_clk, rstn, xWrEn, fetchReq, romEn, serialBaudDouble, cpuPowerDown;
  logic extIrqPinA, extIrqPinB, irqReq, irqAck, irqReti;
  mcuad_pkg::mcuad_sfr_t  sfrReq;
  mcuad_pkg::mcuad_xreq_t xReq;
  mcuad_pkg::mcuad_xsel_t xSel;
  logic [7:0]  sfrRdData, xWrData, xRdData, fetchData, romData, q;
  logic [7:0]  ramRdData, pinRdData, pcrRdData, ctlRdData;
  logic [15:0] xAddr, fetchAddr, romAddr, irqVector;
  logic [14:0] irqSrc;
  logic [3:0]  irqNum, taken;
  logic [1:0]  ackDly;
  logic [31:0] lf = 32'h99465474;
  int          fails = 0, checks = 0, page = 0;

  mcuad_glue i_dut (.core_clk, .rstn, .sfrReq, .sfrRdData, .xReq, .xAddr, .xSel, .xWrEn,
    .xWrData, .ramRdData, .pinRdData, .pcrRdData, .ctlRdData, .xRdData, .fetchReq, .fetchAddr,
    .romEn, .romAddr, .romData, .fetchData, .serialBaudDouble, .cpuPowerDown, .extIrqPinA,
    .extIrqPinB, .irqSrc, .irqReq, .irqNum, .irqVector, .irqAck, .irqReti);
  mcuad_cpu_model i_cpu (.core_clk, .irqReq, .irqNum, .ackDly, .irqAck, .takenNum(taken));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ==========================================================================
  // Tasks and reference model
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function automatic logic [3:0] expSel(input int a);
    if (a <= 'h3C7) return 4'h8;
    if (a >= 'h6100 && a <= 'h61FF) return 4'h4;
    if (a >= 'h6200 && a <= 'h62FF) return 4'h2;
    if (a >= 'h6300 && a <= 'h633F) return 4'h1;
    return 4'h0;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic sfrW(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfrReq = '{1'b1, 1'b0, a, d};
    @(negedge core_clk);
    sfrReq.wrEn = 1'b0;
  endtask
  task automatic sfrR(input logic [7:0] a);
    @(negedge core_clk);
    sfrReq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk);
    sfrReq.rdEn = 1'b0;
    q = sfrRdData;
  endtask
  task automatic xAcc(input logic pg, input logic [15:0] p, input logic [7:0] ix);
    int a;
    logic [3:0] s;
    logic [7:0] e;
    logic w;
    a = pg ? page * 256 + ix : p;
    s = expSel(a);
    w = rnd() % 2;
    @(negedge core_clk);
    xReq = '{1'b1, w, pg, p, ix, 8'(rnd())};
    {ramRdData, pinRdData, pcrRdData, ctlRdData} = rnd();
    e = s[3] ? ramRdData : s[2] ? pinRdData : s[1] ? pcrRdData : s[0] ? ctlRdData : 8'h00;
    #1;
    chk(xAddr, 16'(a));
    chk({12'h000, xSel}, {12'h000, s});
    chk({15'h0, xWrEn}, {15'h0, w && s != 4'h0});
    chk({8'h00, xWrData}, {8'h00, xReq.wrData});
    @(negedge core_clk);
    xReq.req = 1'b0;
    if (!w) chk({8'h00, xRdData}, {8'h00, e});
  endtask
  task automatic fetch(input logic [15:0] a);
    @(negedge core_clk);
    fetchReq = 1'b1;
    fetchAddr = a;
    romData = 8'(rnd());
    #1;
    chk({15'h0, romEn}, {15'h0, a <= 16'hAFFF});
    chk(romAddr, a);
    @(negedge core_clk);
    fetchReq = 1'b0;
    chk({8'h00, fetchData}, {8'h00, a <= 16'hAFFF ? romData : 8'h00});
  endtask
  task automatic irqSee(input int n);
    int k;
    for (k = 0; k < 20 && irqReq !== 1'b1; k++) @(negedge core_clk);
    // Judge on the request itself, so a request seen on the last try still counts
    if (irqReq !== 1'b1) begin
      fails++;
      results();
    end
    chk({12'h000, irqNum}, 16'(n));
    chk(irqVector, 16'h0003 + 16'(n) * 8);
  endtask
  task automatic reti();
    @(negedge core_clk);
    irqReti = 1'b1;
    @(negedge core_clk);
    irqReti = 1'b0;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    static logic [15:0] edges [10] = '{16'h03C7, 16'h03C8, 16'h5FFF, 16'h6000, 16'h60FF, 16'h6100,
                                16'h62FF, 16'h633F, 16'h6340, 16'hFFFF};
    static logic [7:0] regs [6] = '{8'h87, 8'hA8, 8'hB8, 8'hE8, 8'hF8, 8'hFA};
    logic [7:0] d;
    rstn = 1'b0;
    {sfrReq, xReq, fetchReq, fetchAddr, romData, irqSrc, irqAck, irqReti} = '0;
    {ramRdData, pinRdData, pcrRdData, ctlRdData, extIrqPinA, extIrqPinB, ackDly} = '0;
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    foreach (regs[i]) begin
      sfrR(regs[i]);
      chk({8'h00, q}, 16'h0000);
    end
    for (int i = 1; i < 5; i++) begin
      d = rnd() & (i < 3 ? 8'h7F : 8'hFC);
      sfrW(regs[i], d);
      sfrR(regs[i]);
      chk({8'h00, q}, {8'h00, d});
      sfrW(regs[i], 8'h00);
    end
    sfrW(8'h90, 8'hFF);
    sfrR(8'h90);
    chk({8'h00, q}, 16'h0000);
    $display("registers done");
    foreach (edges[i]) xAcc(1'b0, edges[i], 8'h00);
    repeat (30) xAcc(1'b0, 16'(rnd()), 8'h00);
    for (int i = 0; i < 20; i++) begin
      page = (i < 8) ? 8'h60 + i : rnd() % 256;
      sfrW(8'hFA, 8'(page));
      xAcc(1'b1, 16'(rnd()), 8'(rnd()));
    end
    fetch(16'h0000);
    fetch(16'hAFFF);
    fetch(16'hB000);
    repeat (10) fetch(16'(rnd()));
    $display("decode done");
    for (int n = 0; n < 15; n++) begin
      if (n == 7 || n == 8) continue;
      ackDly = 2'(rnd());
      sfrW(8'hA8, 8'h80 | (n < 7 ? 8'(1 << n) : 8'h00));
      sfrW(8'hE8, n > 8 ? 8'(1 << (n - 7)) : 8'h00);
      irqSrc = 15'(1 << n);
      extIrqPinA = (n == 0);
      extIrqPinB = (n == 2);
      irqSee(n);
      repeat (8) @(negedge core_clk);
      chk({12'h000, taken}, 16'(n));
      chk({15'h0, irqReq}, 16'h0000);
      {irqSrc, extIrqPinA, extIrqPinB} = '0;
      reti();
    end
    sfrW(8'hA8, 8'hFF);
    sfrW(8'hE8, 8'hFC);
    sfrW(8'hF8, 8'h80);
    {irqSrc, extIrqPinA, extIrqPinB} = '1;
    irqSee(14);
    repeat (8) @(negedge core_clk);
    chk({15'h0, irqReq}, 16'h0000);
    irqSrc[14] = 1'b0;
    reti();
    irqSee(0);
    repeat (8) @(negedge core_clk);
    irqSrc[14] = 1'b1;
    irqSee(14);
    // Hold the sources until the pre-empting request is taken
    repeat (8) @(negedge core_clk);
    chk({12'h000, taken}, 16'h000E);
    {irqSrc, extIrqPinA, extIrqPinB} = '0;
    repeat (8) @(negedge core_clk);
    reti();
    reti();
    $display("interrupts done");
    sfrW(8'hA8, 8'h7F);
    {irqSrc, extIrqPinA, extIrqPinB} = '1;
    sfrW(8'h87, 8'hFE);
    repeat (6) @(negedge core_clk);
    chk({15'h0, irqReq}, 16'h0000);
    sfrR(8'h87);
    chk({8'h00, q}, 16'h0082);
    chk({14'h0, serialBaudDouble, cpuPowerDown}, 16'h0003);
    sfrW(8'hA8, 8'hFF);
    // Source 14 still holds the high level, so it wins the wake request
    irqSee(14);
    chk({15'h0, cpuPowerDown}, 16'h0000);
    $display("power done");
    results();
  end
endmodule // tb
